//--- hw/gci_pkg.sv
// package: constants and carrier types of the gpio command interpreter
package gci_pkg;
   // ***************************************************************
   // protocol
   // ***************************************************************
   localparam int GCI_PINS = 8;
   localparam int GCI_VEC_BITS = 32;
   localparam int GCI_FRAME_BYTES = 9;
   localparam int GCI_RESP_BYTES = 5;
   localparam int GCI_ERR_BYTES = 1;
   localparam logic [7:0] GCI_CMD_GET_FUNC = 8'h10;
   localparam logic [7:0] GCI_CMD_GET_DIR = 8'h11;
   localparam logic [7:0] GCI_CMD_GET_LVL = 8'h12;
   localparam logic [7:0] GCI_CMD_GET_STATE = 8'h13;
   localparam logic [7:0] GCI_CMD_SET_DIR = 8'h19;
   localparam logic [7:0] GCI_CMD_SET_LVL = 8'h1a;
   localparam logic [7:0] GCI_CMD_SET_STATE = 8'h1b;
   localparam logic [7:0] GCI_ERR_CODE = 8'hff;
   // ***************************************************************
   // register map, byte addresses
   // ***************************************************************
   localparam logic [7:0] GCI_OFS_CTRL = 8'h00;
   localparam logic [7:0] GCI_OFS_FUNC = 8'h04;
   localparam logic [7:0] GCI_OFS_DIR_INIT = 8'h08;
   localparam logic [7:0] GCI_OFS_LVL_INIT = 8'h0c;
   localparam logic [7:0] GCI_OFS_RT_DIR = 8'h10;
   localparam logic [7:0] GCI_OFS_RT_LVL = 8'h14;
   localparam logic [7:0] GCI_OFS_RT_STATE = 8'h18;
   localparam int GCI_CTRL_OFF_BIT = 0;
   localparam int GCI_CTRL_RELOAD_BIT = 1;
   // ***************************************************************
   // reset values and bus response codes
   // ***************************************************************
   localparam logic [7:0] GCI_FUNC_RST = 8'hff;
   localparam logic [7:0] GCI_DIR_RST = 8'h00;
   localparam logic [7:0] GCI_LVL_RST = 8'hff;
   localparam logic [7:0] GCI_STATE_RST = 8'h00;
   localparam logic [1:0] GCI_RESP_OKAY = 2'h0;
   localparam logic [1:0] GCI_RESP_SLVERR = 2'h2;
   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic port_off;
      logic [GCI_PINS-1:0] func;
      logic [GCI_PINS-1:0] dir_init;
      logic [GCI_PINS-1:0] lvl_init;
   } gci_cfg_type;
   typedef struct packed {
      logic [GCI_PINS-1:0] dir;
      logic [GCI_PINS-1:0] lvl;
      logic [GCI_PINS-1:0] state;
   } gci_rt_type;
endpackage

//--- hw/gci_axil_regs.sv
// module: axi4-lite slave holding stored configuration and status view
`timescale 1ns/1ns
module gci_axil_regs
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire gci_pkg::gci_rt_type rt,
   output gci_pkg::gci_cfg_type cfg,
   output logic reload
);
   logic aw_hold_reg;
   logic w_hold_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic wlane_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic do_write;
   logic wr_hit;
   gci_pkg::gci_cfg_type cfg_reg;
   logic reload_reg;

   // ***************************************************************
   // write channel: address and data in either order
   // ***************************************************************
   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready = !w_hold_reg && !bvalid_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_hit = awaddr_reg == gci_pkg::GCI_OFS_CTRL
      || awaddr_reg == gci_pkg::GCI_OFS_FUNC
      || awaddr_reg == gci_pkg::GCI_OFS_DIR_INIT
      || awaddr_reg == gci_pkg::GCI_OFS_LVL_INIT;

   // capture address and data, then answer once both are held
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wlane_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= gci_pkg::GCI_RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wlane_reg <= s_axi_wstrb[0]; // all fields sit in lane 0
         end
         if (do_write)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_hit ? gci_pkg::GCI_RESP_OKAY
                                : gci_pkg::GCI_RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_reg <= 1'b0;
      end
   end

   // stored configuration; reload is a write-one pulse, reads as zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_reg.port_off <= 1'b0;
         cfg_reg.func <= gci_pkg::GCI_FUNC_RST;
         cfg_reg.dir_init <= gci_pkg::GCI_DIR_RST;
         cfg_reg.lvl_init <= gci_pkg::GCI_LVL_RST;
         reload_reg <= 1'b0;
      end
      else
      begin
         reload_reg <= 1'b0;
         if (do_write && wlane_reg)
         begin
            case (awaddr_reg)
               gci_pkg::GCI_OFS_CTRL:
               begin
                  cfg_reg.port_off <= wdata_reg[gci_pkg::GCI_CTRL_OFF_BIT];
                  reload_reg <= wdata_reg[gci_pkg::GCI_CTRL_RELOAD_BIT];
               end
               gci_pkg::GCI_OFS_FUNC: cfg_reg.func <= wdata_reg[7:0];
               gci_pkg::GCI_OFS_DIR_INIT: cfg_reg.dir_init <= wdata_reg[7:0];
               gci_pkg::GCI_OFS_LVL_INIT: cfg_reg.lvl_init <= wdata_reg[7:0];
               default: ;
            endcase
         end
      end
   end

   // ***************************************************************
   // read channel
   // ***************************************************************
   assign s_axi_arready = !rvalid_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= gci_pkg::GCI_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         rvalid_reg <= 1'b1;
         rresp_reg <= gci_pkg::GCI_RESP_OKAY;
         case ({s_axi_araddr[7:2], 2'b00})
            gci_pkg::GCI_OFS_CTRL: rdata_reg <= {31'h0, cfg_reg.port_off};
            gci_pkg::GCI_OFS_FUNC: rdata_reg <= {24'h0, cfg_reg.func};
            gci_pkg::GCI_OFS_DIR_INIT: rdata_reg <= {24'h0, cfg_reg.dir_init};
            gci_pkg::GCI_OFS_LVL_INIT: rdata_reg <= {24'h0, cfg_reg.lvl_init};
            gci_pkg::GCI_OFS_RT_DIR: rdata_reg <= {24'h0, rt.dir};
            gci_pkg::GCI_OFS_RT_LVL: rdata_reg <= {24'h0, rt.lvl};
            gci_pkg::GCI_OFS_RT_STATE: rdata_reg <= {24'h0, rt.state};
            default:
            begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= gci_pkg::GCI_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign cfg = cfg_reg;
   assign reload = reload_reg;
endmodule

//--- hw/gci_gpio_cmd.sv
// module: gpio command interpreter top with byte streams and pins
`timescale 1ns/1ns
// How it works
// - eight real pins, protocol vectors hold 32
// - reset: gpio function, input, active low
// - each pin function chosen independently
// - power-up settings from stored config registers
// - vectors little endian, pin 0 bit 0
// - non-gpio bits read zero in command answers, writes ignored
// - every command frame is nine bytes
// - unused parameter bytes accepted and ignored
// - valid command answers echo plus four bytes
// - unknown command answers ffh, changes nothing
// - byte 0 selects the operation code
// - 10h returns function vector
// - 11h returns direction vector, 1 is output
// - 12h returns polarity vector, 1 active low
// - 13h returns logical pin states
// - no command changes pin functions
// - written settings volatile, revert on reload
// - writes update only masked pins
// - state write answers resulting state vector
// - state bit 1 means active
module gci_gpio_cmd
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic [gci_pkg::GCI_PINS-1:0] pin_in,
   output logic [gci_pkg::GCI_PINS-1:0] pin_out,
   output logic [gci_pkg::GCI_PINS-1:0] pin_oe
);
   typedef enum {GCI_ST_RX, GCI_ST_EXEC, GCI_ST_TX} gci_state_type;

   localparam int FB = gci_pkg::GCI_FRAME_BYTES;
   localparam int NP = gci_pkg::GCI_PINS;

   gci_state_type st_reg;
   logic [FB*8-1:0] frame_reg;
   logic [3:0] rx_cnt_reg;
   logic [3:0] tx_cnt_reg;
   logic [39:0] resp_reg;
   logic [NP-1:0] dir_reg;
   logic [NP-1:0] lvl_reg;
   logic [NP-1:0] ost_reg;
   logic [NP-1:0] dir_next;
   logic [NP-1:0] lvl_next;
   logic [NP-1:0] ost_next;
   logic [NP-1:0] mask;
   logic [NP-1:0] newval;
   logic [NP-1:0] view_next;
   logic [NP-1:0] view_now;
   logic [NP-1:0] resp_vec;
   logic cmd_ok;
   logic [7:0] cmd;
   logic rx_take;
   logic tx_take;
   logic reload;
   gci_pkg::gci_cfg_type cfg;
   gci_pkg::gci_rt_type rt;

   // ***************************************************************
   // register bus
   // ***************************************************************
   gci_axil_regs u_regs
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rt(rt),
      .cfg(cfg),
      .reload(reload)
   );

   // ***************************************************************
   // frame reception
   // ***************************************************************
   assign rx_ready = st_reg == GCI_ST_RX;
   assign rx_take = rx_valid && rx_ready;
   assign tx_valid = st_reg == GCI_ST_TX;
   assign tx_take = tx_valid && tx_ready;
   assign tx_data = resp_reg[7:0];

   // bytes shift in from the top, so byte 0 lands in bits 7:0
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         frame_reg <= '0;
      else if (rx_take)
         frame_reg <= {rx_data, frame_reg[FB*8-1:8]};
   end

   // operation byte and parameter fields of the held frame
   assign cmd = frame_reg[7:0];
   assign mask = frame_reg[8 +: NP] & cfg.func;
   assign newval = frame_reg[40 +: NP];

   // ***************************************************************
   // sequencing
   // ***************************************************************
   // one frame at a time: no byte is taken while an answer is pending
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_reg <= GCI_ST_RX;
         rx_cnt_reg <= 4'h0;
      end
      else
      begin
         case (st_reg)
            GCI_ST_RX:
               if (rx_take)
               begin
                  if (rx_cnt_reg == 4'(FB - 1))
                  begin
                     rx_cnt_reg <= 4'h0;
                     st_reg <= GCI_ST_EXEC;
                  end
                  else
                     rx_cnt_reg <= rx_cnt_reg + 4'h1;
               end
            GCI_ST_EXEC:
               // a disabled port drops the frame with no answer
               st_reg <= cfg.port_off ? GCI_ST_RX : GCI_ST_TX;
            GCI_ST_TX:
               if (tx_take && tx_cnt_reg == 4'h1)
                  st_reg <= GCI_ST_RX;
            default: st_reg <= GCI_ST_RX;
         endcase
      end
   end

   // ***************************************************************
   // command decode
   // ***************************************************************
   // merge masked new bits; next values equal the current ones on reads
   always_comb
   begin
      dir_next = dir_reg;
      lvl_next = lvl_reg;
      ost_next = ost_reg;
      cmd_ok = 1'b1;
      case (cmd)
         gci_pkg::GCI_CMD_GET_FUNC,
         gci_pkg::GCI_CMD_GET_DIR,
         gci_pkg::GCI_CMD_GET_LVL,
         gci_pkg::GCI_CMD_GET_STATE: ;
         gci_pkg::GCI_CMD_SET_DIR:
            dir_next = (dir_reg & ~mask) | (newval & mask);
         gci_pkg::GCI_CMD_SET_LVL:
            lvl_next = (lvl_reg & ~mask) | (newval & mask);
         gci_pkg::GCI_CMD_SET_STATE:
            ost_next = (ost_reg & ~mask) | (newval & mask);
         default: cmd_ok = 1'b0;
      endcase
   end

   // logical state: driven value for outputs, decoded level for inputs
   assign view_next = (dir_next & ost_next)
      | (~dir_next & (pin_in ^ lvl_next));
   assign view_now = (dir_reg & ost_reg)
      | (~dir_reg & (pin_in ^ lvl_reg));

   // answer vector; bits of dedicated pins are forced to zero
   always_comb
   begin
      case (cmd)
         gci_pkg::GCI_CMD_GET_FUNC: resp_vec = cfg.func;
         gci_pkg::GCI_CMD_GET_DIR,
         gci_pkg::GCI_CMD_SET_DIR: resp_vec = dir_next & cfg.func;
         gci_pkg::GCI_CMD_GET_LVL,
         gci_pkg::GCI_CMD_SET_LVL: resp_vec = lvl_next & cfg.func;
         gci_pkg::GCI_CMD_GET_STATE,
         gci_pkg::GCI_CMD_SET_STATE:
            resp_vec = view_next & cfg.func;
         default: resp_vec = '0;
      endcase
   end

   // ***************************************************************
   // answer shift register
   // ***************************************************************
   // built in the execute cycle, shifted out one byte per handshake
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         resp_reg <= 40'h00_0000_0000;
         tx_cnt_reg <= 4'h0;
      end
      else if (st_reg == GCI_ST_EXEC)
      begin
         if (cmd_ok)
         begin
            resp_reg <= {{(32-NP){1'b0}}, resp_vec, cmd};
            tx_cnt_reg <= 4'(gci_pkg::GCI_RESP_BYTES);
         end
         else
         begin
            resp_reg <= {32'h0000_0000, gci_pkg::GCI_ERR_CODE};
            tx_cnt_reg <= 4'(gci_pkg::GCI_ERR_BYTES);
         end
      end
      else if (tx_take)
      begin
         resp_reg <= {8'h00, resp_reg[39:8]};
         tx_cnt_reg <= tx_cnt_reg - 4'h1;
      end
   end

   // ***************************************************************
   // runtime pin settings
   // ***************************************************************
   // reload stands for a reboot and wins over a command in flight
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         dir_reg <= gci_pkg::GCI_DIR_RST;
         lvl_reg <= gci_pkg::GCI_LVL_RST;
         ost_reg <= gci_pkg::GCI_STATE_RST;
      end
      else if (reload)
      begin
         dir_reg <= cfg.dir_init;
         lvl_reg <= cfg.lvl_init;
         ost_reg <= gci_pkg::GCI_STATE_RST;
      end
      else if (st_reg == GCI_ST_EXEC && cmd_ok && !cfg.port_off)
      begin
         dir_reg <= dir_next;
         lvl_reg <= lvl_next;
         ost_reg <= ost_next;
      end
   end

   // ***************************************************************
   // pin drivers
   // ***************************************************************
   // dedicated pins are never driven; the flop costs one cycle but
   // keeps decode glitches off the pads
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_oe <= gci_pkg::GCI_DIR_RST & gci_pkg::GCI_FUNC_RST;
         pin_out <= gci_pkg::GCI_STATE_RST ^ gci_pkg::GCI_LVL_RST;
      end
      else
      begin
         pin_oe <= dir_reg & cfg.func;
         pin_out <= ost_reg ^ lvl_reg;
      end
   end

   // live settings for the status registers
   assign rt.dir = dir_reg;
   assign rt.lvl = lvl_reg;
   assign rt.state = view_now;
endmodule

//--- verif/gci_host_model.sv
// model: remote host that sends command frames and collects answers
`timescale 1ns/1ns
module gci_host_model
(
   input wire logic aclk,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready
);
   int stall;
   // idle until the bench asks for a frame
   initial
   begin
      rx_data = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
      stall = 0;
   end
   // ***************************************************************
   // one command: nine bytes out, then n answer bytes in
   // ***************************************************************
   // the whole frame goes out at once, byte 0 first
   task automatic xfer(input logic [71:0] f, input int n,
                       output logic [39:0] r);
      int i;
      for (i = 0; i < 9; i++)
      begin
         rx_data <= f[71-8*i -: 8];
         rx_valid <= 1'b1;
         do @(posedge aclk); while (!rx_ready);
      end
      rx_valid <= 1'b0;
      rx_data <= ~f[7:0]; // released line must not show the last byte
      r = '0;
      // no new frame before the answer is
      for (i = 0; i < n; i++)
      begin
         if (stall > 0)
         begin
            tx_ready <= 1'b0;
            repeat (stall) @(posedge aclk);
         end
         tx_ready <= 1'b1;
         do @(posedge aclk); while (!tx_valid);
         r = {r[31:0], tx_data};
      end
      tx_ready <= 1'b0;
   endtask
endmodule

//--- verif/gci_gpio_cmd_checker.sv
// checker: timing properties at the command interpreter ports
`timescale 1ns/1ns
module gci_gpio_cmd_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   input wire logic [7:0] tx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe
);
   logic [3:0] rx_cnt_reg;
   logic [2:0] tx_cnt_reg;
   logic [7:0] cmd_reg;
   logic last_rx;
   logic cmd_ok;
   assign last_rx = rx_valid && rx_ready && rx_cnt_reg == 4'h8;
   assign cmd_ok = cmd_reg inside {[8'h10:8'h13], [8'h19:8'h1b]};
   // byte position in the frame; there is no sync, only the count
   always_ff @(posedge aclk)
   begin
      if (!aresetn || last_rx)
         rx_cnt_reg <= 4'h0;
      else if (rx_valid && rx_ready)
         rx_cnt_reg <= rx_cnt_reg + 4'h1;
   end
   // byte position in the answer
   always_ff @(posedge aclk)
   begin
      if (!aresetn || last_rx)
         tx_cnt_reg <= 3'h0;
      else if (tx_valid && tx_ready)
         tx_cnt_reg <= tx_cnt_reg + 3'h1;
   end
   // command byte of the frame in flight
   always_ff @(posedge aclk)
   begin
      if (rx_valid && rx_ready && rx_cnt_reg == 4'h0)
         cmd_reg <= rx_data;
   end
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_frame_answer: assert property (last_rx |=> !rx_ready ##1
      (tx_valid != rx_ready)) else $error("no answer two cycles on");
   a_echo_first: assert property (tx_valid && tx_cnt_reg == 3'h0
      |-> tx_data == (cmd_ok ? cmd_reg : 8'hff)) else $error("bad echo");
   a_upper_zero: assert property (tx_valid && tx_cnt_reg >= 3'h2
      |-> tx_data == 8'h00) else $error("pins above 8 not zero");
   a_answer_len: assert property (tx_valid && tx_ready &&
      (tx_cnt_reg == 3'h4 || !cmd_ok && tx_cnt_reg == 3'h0)
      |=> !tx_valid && rx_ready) else $error("answer length wrong");
   a_tx_hold: assert property (tx_valid && !tx_ready
      |=> tx_valid && $stable(tx_data)) else $error("tx byte dropped");
   a_no_rx_busy: assert property (tx_valid |-> !rx_ready)
      else $error("rx open while answering");
   a_reset_pins: assert property ($rose(aresetn)
      |-> pin_oe == 8'h00 && pin_out == 8'hff) else $error("pin reset");
   a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
      && s_axi_araddr > 8'h1b |=> s_axi_rvalid && s_axi_rresp == 2'h2
      && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
endmodule
bind gci_gpio_cmd gci_gpio_cmd_checker gci_gpio_cmd_checker_inst
(
   .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .rx_data, .rx_valid,
   .rx_ready, .tx_data, .tx_valid, .tx_ready, .pin_out, .pin_oe
);

//--- verif/gci_gpio_cmd_test.sv
// testbench: frames, register accesses and pins of the interpreter
`timescale 1ns/1ns
module gci_gpio_cmd_test;
   typedef struct packed
   {
      logic [7:0] cmd;
      logic [31:0] p1;
      logic [31:0] p2;
      logic [31:0] v;
   } gci_row_type;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic rx_valid, rx_ready, tx_valid, tx_ready;
   logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data;
   logic [7:0] pin_in, pin_out, pin_oe;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [39:0] r;
   int mismatches, n_tests;
   // pin_in 5a, all pins inputs and active low at the start
   gci_row_type rows [11] = '{
      '{8'h10, 32'h12345678, 32'h9abcdef0, 32'hff},
      '{8'h11, 32'h0, 32'h0, 32'h00},
      '{8'h12, 32'h0, 32'h0, 32'hff},
      '{8'h13, 32'h0, 32'h0, 32'ha5},
      '{8'h19, 32'hffff000f, 32'h12340005, 32'h05},
      '{8'h1a, 32'hf0, 32'h30, 32'h3f},
      '{8'h1b, 32'hff, 32'h81, 32'h61},
      '{8'h55, 32'hff, 32'hff, 32'h0},
      '{8'h14, 32'hff, 32'hff, 32'h0},
      '{8'h11, 32'h0, 32'h0, 32'h05},
      '{8'h12, 32'h0, 32'h0, 32'h3f}};
   gci_gpio_cmd gci_gpio_cmd_inst (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_data,
      .rx_valid, .rx_ready, .tx_data, .tx_valid, .tx_ready, .pin_in,
      .pin_out, .pin_oe);
   gci_host_model gci_host_model_inst (.aclk, .rx_data, .rx_valid,
      .rx_ready, .tx_data, .tx_valid, .tx_ready);
   // 20 MHz
   always #25 aclk = ~aclk;
   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic check(input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] le(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction
   // unknown codes answer with one byte only
   task automatic run(input logic [7:0] c, input logic [31:0] p1, p2, v);
      logic ok;
      ok = c inside {[8'h10:8'h13], [8'h19:8'h1b]};
      gci_host_model_inst.xfer({c, le(p1), le(p2)}, ok ? 5 : 1, r);
      check(r, ok ? {c, le(v)} : 40'hff);
   endtask
   // address and data offered together, released as each is taken
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic ga, gw;
      {ga, gw} = 2'b00;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_wstrb <= 4'h1;
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      while (!(ga && gw))
      begin
         @(posedge aclk);
         ga = ga | s_axi_awready;
         gw = gw | s_axi_wready;
         if (ga) s_axi_awvalid <= 1'b0;
         if (gw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b1;
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_rvalid);
      {rs, d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'b0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // ***************************************************************
   // sequence
   // ***************************************************************
   initial
   begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, s_axi_wstrb, mismatches, n_tests} = '0;
      pin_in = 8'h5a;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check({pin_oe, pin_out, rx_ready, tx_valid}, 18'h003fe);
      $display("reset test done");
      foreach (rows[i])
         run(rows[i].cmd, rows[i].p1, rows[i].p2, rows[i].v);
      check({pin_oe, pin_out & pin_oe}, 16'h0504);
      $display("table test done");
      // slow host: inputs now 0f ^ 3f, pin 0 output still active
      pin_in <= 8'h0f;
      gci_host_model_inst.stall = 3;
      run(8'h13, 32'h0, 32'h0, 32'h31);
      gci_host_model_inst.stall = 0;
      axr(gci_pkg::GCI_OFS_RT_STATE);
      check({rs, d}, {2'h0, 32'h31});
      axr(8'h40);
      check({rs, d}, {2'h2, 32'h0});
      axw(8'h44, 32'h1);
      check(rs, 2'h2);
      // pin 0 leaves gpio: its bits read 0 and writes to it are void
      axw(gci_pkg::GCI_OFS_FUNC, 32'hfe);
      run(8'h10, 32'h0, 32'h0, 32'hfe);
      run(8'h19, 32'hff, 32'hff, 32'hfe);
      check(pin_oe, 8'hfe);
      $display("function test done");
      axw(gci_pkg::GCI_OFS_DIR_INIT, 32'h0f);
      axw(gci_pkg::GCI_OFS_CTRL, 32'h2);
      run(8'h11, 32'h0, 32'h0, 32'h0e);
      axw(gci_pkg::GCI_OFS_CTRL, 32'h1);
      gci_host_model_inst.xfer({8'h19, le(32'hff), le(32'h0)}, 0, r);
      repeat (10) @(posedge aclk);
      check({tx_valid, rx_ready}, 2'b01);
      axw(gci_pkg::GCI_OFS_CTRL, 32'h0);
      run(8'h11, 32'h0, 32'h0, 32'h0e);
      $display("reload and disable test done");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      run(8'h11, 32'h0, 32'h0, 32'h00);
      $display("second reset test done");
      wrap_up();
   end
   // whole run is a few hundred cycles; forty thousand means a hang
   initial
   begin
      #2000000;
      mismatches++;
      wrap_up();
   end
endmodule
